// File: design/cps_pkg.sv
// Package with constants and carriers for the configuration port control block
package cps_pkg;
    // Register select values
    localparam logic SEL_COMMAND = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    localparam logic [7:0] STATUS_OFFSET = 8'h01;
    // Command byte field positions
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_OUT_EN_BIT = 4;
    localparam int CMD_IN_EN_BIT = 5;
    localparam int CMD_OSC_DIS_BIT = 6;
    localparam int CMD_BOOT_EN_BIT = 7;
    // Command codes
    localparam logic [3:0] CODE_NOP = 4'h0;
    localparam logic [3:0] CODE_RESET_DEV = 4'h1;
    localparam logic [3:0] CODE_LOAD_CFG = 4'h2;
    localparam logic [3:0] CODE_RESERVED = 4'h7;
    // Status byte field positions
    localparam int ST_ID_ERR_BIT = 0;
    localparam int ST_ROW_ERR_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // Internal oscillator divided by eight for the configuration clock
    localparam int OSC_DIV = 8;
    localparam logic [2:0] OSC_DIV_LAST = 3'h7;
    // Restart wait after oscillator re-enable, kept by the host
    localparam int OSC_RESTART_US = 100;
    localparam int REF_CLK_MHZ = 250;
    localparam int OSC_RESTART_CYC = OSC_RESTART_US * REF_CLK_MHZ;

    // Control bits latched from a command write
    typedef struct packed {
        logic bootEn;
        logic oscDis;
        logic inEn;
        logic outEn;
    } cps_ctrl_s;

    // Error and busy sources from the configuration engine
    typedef struct packed {
        logic idErr;
        logic rowErr;
        logic busy;
    } cps_event_s;
endpackage

// File: design/cps_clk_div.sv
// Internal oscillator gate and divide-by-eight configuration clock enable
`timescale 1ns/1ps
module cps_clk_div
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic clkEn, // Clock enable
    input wire logic oscRun, // Oscillator allowed to run
    input wire logic oscTick, // One ring oscillator period elapsed
    output logic cfgTick_r // Configuration clock enable pulse
);
    import cps_pkg::*;

    logic [2:0] divCnt_r;

    // Count oscillator ticks and pulse every eighth
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            divCnt_r <= 3'h0;
            cfgTick_r <= 1'b0;
        end
        else if (clkEn)
        begin
            cfgTick_r <= 1'b0;
            if (oscRun && oscTick)
            begin
                divCnt_r <= divCnt_r + 3'h1;
                cfgTick_r <= (divCnt_r == OSC_DIV_LAST);
            end
        end
    end
endmodule

// File: design/cps_port_ctrl.sv
// Processor port command and status logic of the configuration interface
`timescale 1ns/1ps
// How it works
// - Command codes 0111 and 1xxx are reserved and only latch the control bits.
// - User output pins are driven only while the outputs enable bit is set.
// - User input values pass inward only while the inputs enable bit is set.
// - Oscillator stops on its disable bit only with external clock chosen.
// - Status bit 0 flags an ID mismatch and bit 1 a row check mismatch.
// - Status bit 2 mirrors the busy output.
// - Status bits 7 to 3 are reserved and the host ignores them.
// - Register select high addresses data, low the command on writes and status on reads.
// - After an error flag, data writes are refused until reset or load.
// - During a load any data register read returns the status byte.
module cps_port_ctrl
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic clkEn, // Clock enable, freezes all state when low
    input wire logic chipSelN, // Port chip select pin, active low
    input wire logic writeStbN, // Port write strobe pin, active low
    input wire logic readStbN, // Port read strobe pin, active low
    input wire logic registerSelect, // Register select pin
    input wire logic [7:0] dataIn, // Port data pins in
    output logic [7:0] dataOut_r, // Port data pins out
    output logic dataOe_r, // Port data output enable
    input wire logic extClkSel, // Clock source select bit 2 pin
    input wire logic oscTick, // Ring oscillator period tick
    input wire cps_pkg::cps_event_s engEvt, // Engine error and busy events
    input wire logic [7:0] engRdData, // Engine read data for data reads
    output logic busy_r, // Busy pin
    output logic [3:0] cmdCode_r, // Last defined command code
    output logic cmdStb_r, // Pulse on a defined command write other than NOP
    output logic [7:0] wrData_r, // Accepted data byte
    output logic wrStb_r, // Pulse on an accepted data write
    output logic rdStb_r, // Pulse on a data read for row or ID data
    output cps_pkg::cps_ctrl_s ctrl_r, // Latched control bits
    output logic oscRun_r, // Internal oscillator running
    output logic cfgTick_r, // Configuration clock enable
    input wire logic [15:0] userIn, // User input pins
    output logic [15:0] userInArr_r, // User inputs passed to the array
    input wire logic [15:0] userOutArr, // Array values for user outputs
    output logic [15:0] userOut_r, // User output pin values
    output logic [15:0] userOe_r // User output pin enables
);
    import cps_pkg::*;

    logic [2:0] csSync_r, wrSync_r, rdSync_r;
    logic [1:0] rsSync_r, extSync_r;
    logic [7:0] dinS1_r, dinS2_r;
    logic [15:0] uinS1_r, uinS2_r;
    logic wrFall, rdFall, loading_r, errLock_r, idErr_r, rowErr_r;
    logic [7:0] statusByte;
    logic [3:0] code;
    logic reservedCode;

    // Two-flop synchronisers; third stage only for edge detection
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            csSync_r <= 3'h7;
            wrSync_r <= 3'h7;
            rdSync_r <= 3'h7;
            rsSync_r <= 2'h0;
            extSync_r <= 2'h0;
            dinS1_r <= 8'h00;
            dinS2_r <= 8'h00;
            uinS1_r <= 16'h0000;
            uinS2_r <= 16'h0000;
        end
        else if (clkEn)
        begin
            csSync_r <= {csSync_r[1:0], chipSelN};
            wrSync_r <= {wrSync_r[1:0], writeStbN};
            rdSync_r <= {rdSync_r[1:0], readStbN};
            rsSync_r <= {rsSync_r[0], registerSelect};
            extSync_r <= {extSync_r[0], extClkSel};
            dinS1_r <= dataIn;
            dinS2_r <= dinS1_r;
            uinS1_r <= userIn;
            uinS2_r <= uinS1_r;
        end
    end

    // Strobe falling edges with chip select low
    assign wrFall = wrSync_r[2] && !wrSync_r[1] && !csSync_r[1];
    assign rdFall = rdSync_r[2] && !rdSync_r[1] && !csSync_r[1];
    assign code = dinS2_r[CMD_CODE_LSB +: 4];
    assign reservedCode = code[3] || (code == CODE_RESERVED);

    // Status byte, reserved upper bits read as zero
    always_comb
    begin
        statusByte = STATUS_RESET;
        statusByte[ST_ID_ERR_BIT] = idErr_r;
        statusByte[ST_ROW_ERR_BIT] = rowErr_r;
        statusByte[ST_BUSY_BIT] = busy_r;
    end

    // Command write: code and control bits from one byte
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            ctrl_r <= CTRL_RESET;
            cmdCode_r <= CODE_NOP;
            cmdStb_r <= 1'b0;
            loading_r <= 1'b0;
        end
        else if (clkEn)
        begin
            cmdStb_r <= 1'b0;
            if (wrFall && rsSync_r[1] == SEL_COMMAND)
            begin
                ctrl_r.bootEn <= dinS2_r[CMD_BOOT_EN_BIT];
                ctrl_r.oscDis <= dinS2_r[CMD_OSC_DIS_BIT];
                ctrl_r.inEn <= dinS2_r[CMD_IN_EN_BIT];
                ctrl_r.outEn <= dinS2_r[CMD_OUT_EN_BIT];
                if (!reservedCode)
                begin
                    cmdCode_r <= code;
                    cmdStb_r <= (code != CODE_NOP);
                    if (code == CODE_LOAD_CFG)
                        loading_r <= 1'b1;
                    else if (code != CODE_NOP)
                        loading_r <= 1'b0;
                end
            end
        end
    end

    // Sticky error flags; set wins over clear by a new load or reset
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            idErr_r <= 1'b0;
            rowErr_r <= 1'b0;
            errLock_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wrFall && rsSync_r[1] == SEL_COMMAND && !reservedCode
                && (code == CODE_LOAD_CFG || code == CODE_RESET_DEV))
            begin
                idErr_r <= engEvt.idErr;
                rowErr_r <= engEvt.rowErr;
                errLock_r <= engEvt.idErr || engEvt.rowErr;
            end
            else
            begin
                idErr_r <= idErr_r || engEvt.idErr;
                rowErr_r <= rowErr_r || engEvt.rowErr;
                errLock_r <= errLock_r || engEvt.idErr || engEvt.rowErr;
            end
        end
    end

    // Data writes are refused while locked or busy
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            wrData_r <= 8'h00;
            wrStb_r <= 1'b0;
        end
        else if (clkEn)
        begin
            wrStb_r <= 1'b0;
            if (wrFall && rsSync_r[1] == SEL_DATA && !errLock_r
                && !busy_r)
            begin
                wrData_r <= dinS2_r;
                wrStb_r <= 1'b1;
            end
        end
    end

    // Data reads: status during a load, engine data otherwise
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            dataOut_r <= 8'h00;
            dataOe_r <= 1'b0;
            rdStb_r <= 1'b0;
        end
        else if (clkEn)
        begin
            rdStb_r <= 1'b0;
            dataOe_r <= !rdSync_r[1] && !csSync_r[1];
            if (rdFall && rsSync_r[1] == SEL_DATA)
            begin
                if (loading_r)
                    dataOut_r <= statusByte;
                else
                begin
                    dataOut_r <= engRdData;
                    rdStb_r <= 1'b1;
                end
            end
            else if (rdFall)
                dataOut_r <= statusByte;
        end
    end

    // Busy pin follows the engine
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            busy_r <= 1'b1;
        else if (clkEn)
            busy_r <= engEvt.busy;
    end

    // Oscillator may stop only with the external clock selected
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            oscRun_r <= 1'b1;
        else if (clkEn)
            oscRun_r <= !(ctrl_r.oscDis && extSync_r[1]);
    end

    // User input and output gating per pin
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_user
            always_ff @(posedge ref_clk)
            begin
                if (!nrst)
                begin
                    userInArr_r[i] <= 1'b0;
                    userOut_r[i] <= 1'b0;
                    userOe_r[i] <= 1'b0;
                end
                else if (clkEn)
                begin
                    userInArr_r[i] <= ctrl_r.inEn && uinS2_r[i];
                    userOut_r[i] <= userOutArr[i];
                    userOe_r[i] <= ctrl_r.outEn;
                end
            end
        end
    endgenerate

    // Configuration clock from the divided oscillator
    cps_clk_div u_div
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .oscRun(oscRun_r),
        .oscTick(oscTick),
        .cfgTick_r(cfgTick_r)
    );
endmodule

// File: bench/cps_port_ctrl_sva.sv
// Checker for the configuration port control block
`timescale 1ns/1ps
module cps_port_ctrl_sva
(
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic extClkSel, // External clock chosen
    input wire cps_pkg::cps_event_s engEvt, // Engine events
    input wire logic busy_r, // Busy pin
    input wire logic [3:0] cmdCode_r, // Command code
    input wire logic cmdStb_r, // Command pulse
    input wire logic wrStb_r, // Data write pulse
    input wire cps_pkg::cps_ctrl_s ctrl_r, // Control bits
    input wire logic oscRun_r, // Oscillator running
    input wire logic cfgTick_r, // Config clock enable
    input wire logic [15:0] userInArr_r, // Inputs to array
    input wire logic [15:0] userOe_r // Output enables
);
    import cps_pkg::*;
    logic errLock_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // Sticky error lock, cleared by a load or device reset command
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            errLock_r <= 1'b0;
        else if (engEvt.idErr || engEvt.rowErr)
            errLock_r <= 1'b1;
        else if (cmdStb_r && cmdCode_r inside {CODE_LOAD_CFG, CODE_RESET_DEV})
            errLock_r <= 1'b0;
    end
    a_reserved_code: assert property (cmdStb_r |->
        cmdCode_r inside {[4'h1:4'h6]}) else $error("reserved code pulsed");
    a_out_gate: assert property ((!ctrl_r.outEn)[*3] |->
        userOe_r == 16'h0000) else $error("outputs driven while off");
    a_in_gate: assert property ((!ctrl_r.inEn)[*3] |->
        userInArr_r == 16'h0000) else $error("inputs passed while off");
    a_osc_keep: assert property ((!extClkSel)[*4] |-> oscRun_r)
        else $error("oscillator stopped on internal clock");
    a_osc_stop: assert property ((extClkSel && ctrl_r.oscDis)[*4] |->
        !oscRun_r) else $error("oscillator kept running");
    a_tick_div: assert property (cfgTick_r |=> (!cfgTick_r)[*7])
        else $error("config tick faster than one in eight");
    a_busy_follow: assert property ($changed(engEvt.busy) |=>
        busy_r == $past(engEvt.busy)) else $error("busy not mirrored");
    a_err_lock: assert property (errLock_r[*4] |-> !wrStb_r)
        else $error("data write taken while locked");
    c_load: cover property (cmdStb_r && cmdCode_r == CODE_LOAD_CFG);
    c_write: cover property (wrStb_r);
    c_osc_off: cover property (!oscRun_r);
endmodule
bind cps_port_ctrl cps_port_ctrl_sva i_cps_port_ctrl_sva (.*);

// File: bench/cps_host.sv
// Host processor model on the byte-wide configuration port
`timescale 1ns/1ps
module cps_host
#(
    parameter int RESTART_CYC = cps_pkg::OSC_RESTART_CYC // Restart wait
)
(
    input wire logic ref_clk, // Clock
    input wire logic busy_r, // Busy pin
    input wire logic [7:0] dataOut_r, // Read data
    output logic chipSelN = 1'b1, // Chip select
    output logic writeStbN = 1'b1, // Write strobe
    output logic readStbN = 1'b1, // Read strobe
    output logic registerSelect = 1'b0, // Register select
    output logic [7:0] dataIn = 8'h00 // Data to device
);
    import cps_pkg::*;
    bit ignoreBusy = 1'b0;
    bit oscOff = 1'b0;
    // One port cycle: strobe low five cycles, then high three
    task automatic access(input logic rs, input logic wr,
        input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        while (wr && rs && !ignoreBusy && busy_r !== 1'b0 && n < 999)
        begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        #1;
        {chipSelN, registerSelect, writeStbN, readStbN} = {1'b0, rs, !wr, wr};
        dataIn = wr ? d : ~dataIn;
        repeat (5) @(posedge ref_clk);
        q = dataOut_r;
        #1;
        {chipSelN, writeStbN, readStbN} = 3'h7;
        dataIn = ~dataIn; // Released bus shows no stale byte
        repeat (3) @(posedge ref_clk);
        if (wr && !rs && oscOff && !d[CMD_OSC_DIS_BIT])
            repeat (RESTART_CYC) @(posedge ref_clk);
        if (wr && !rs)
            oscOff = d[CMD_OSC_DIS_BIT];
        #1;
    endtask
endmodule

// File: bench/cps_port_ctrl_tb.sv
// Testbench for the configuration port control block
`timescale 1ns/1ps
module cps_port_ctrl_tb;
    import cps_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic extClkSel = 1'b0;
    logic oscTick = 1'b0;
    logic chipSelN, writeStbN, readStbN, registerSelect, dataOe_r, busy_r;
    logic cmdStb_r, wrStb_r, rdStb_r, oscRun_r, cfgTick_r;
    logic [3:0] cmdCode_r;
    logic [7:0] dataIn, dataOut_r, wrData_r, q;
    logic [7:0] engRdData = 8'h5A;
    logic [15:0] userIn = 16'h0000;
    logic [15:0] userOutArr = 16'h9C36;
    logic [15:0] userInArr_r, userOut_r, userOe_r;
    cps_event_s engEvt = '0;
    cps_ctrl_s ctrl_r;
    int num_errors = 0, n_compared = 0, cyc = 0;
    int nCmd = 0, nWr = 0, nRd = 0, nTick = 0, nOe = 0;
    cps_port_ctrl i_cps_port_ctrl (.*);
    // Host keeps the full oscillator restart wait
    cps_host i_cps_host (.*);
    initial
        forever #2 ref_clk = ~ref_clk;
    // Pulse counters, oscillator ticks and hang limit
    always @(posedge ref_clk)
    begin
        nCmd += cmdStb_r;
        nWr += wrStb_r;
        nRd += rdStb_r;
        nTick += cfgTick_r;
        nOe += dataOe_r;
        cyc++;
        oscTick <= (cyc[1:0] == 2'h0);
        // Three oscillator restart waits dominate the run time
        if (cyc == 85000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Command codes 0 to 8 and F with varied control bits
    task automatic t_cmd();
        logic [39:0] codes = 40'h012345678F;
        logic [3:0] c, last = 4'h0;
        int n;
        for (int i = 0; i < 10; i++)
        begin
            c = codes[39 - 4 * i -: 4];
            n = nCmd;
            i_cps_host.access(1'b0, 1'b1, {1'b0, c[2:1], 1'b0, c}, q);
            last = (c inside {[1:6]}) ? c : last;
            chk(nCmd - n, (c inside {[1:6]}) ? 1 : 0);
            chk(cmdCode_r, last);
            chk(ctrl_r, {1'b0, c[2:1], 1'b0});
        end
    endtask
    // Data read, status during load, error lock and busy refusal
    task automatic t_load();
        int r = nRd, w = nWr, o = nOe;
        i_cps_host.access(1'b0, 1'b1, 8'h06, q);
        i_cps_host.access(1'b1, 1'b0, 8'h00, q);
        chk(q, engRdData);
        chk(nOe - o, 5);
        i_cps_host.access(1'b0, 1'b1, 8'h02, q);
        engEvt = 3'b111;
        step(1);
        engEvt = 3'b001;
        i_cps_host.access(1'b1, 1'b0, 8'h00, q);
        chk(q, 8'h07);
        chk(nRd - r, 1);
        engEvt = 3'b000;
        i_cps_host.access(1'b1, 1'b1, 8'hC3, q);
        chk(nWr - w, 0);
        i_cps_host.access(1'b0, 1'b1, 8'h02, q);
        i_cps_host.access(1'b1, 1'b1, 8'h3C, q);
        chk(wrData_r, 8'h3C);
        engEvt = 3'b001;
        i_cps_host.ignoreBusy = 1'b1;
        i_cps_host.access(1'b1, 1'b1, 8'h99, q);
        chk(nWr - w, 1);
        i_cps_host.ignoreBusy = 1'b0;
        engEvt = 3'b000;
    endtask
    // Input gating, then output gating with the boot bit set
    task automatic t_user();
        userIn = 16'hA5C3;
        step(4);
        chk(userInArr_r, 16'h0000);
        i_cps_host.access(1'b0, 1'b1, 8'h20, q);
        chk(userInArr_r, 16'hA5C3);
        chk(userOe_r, 16'h0000);
        i_cps_host.access(1'b0, 1'b1, 8'hB0, q);
        chk(userOe_r, 16'hFFFF);
        chk(userOut_r, userOutArr);
    endtask
    // Oscillator disable honoured only with external clock
    task automatic t_osc();
        int t;
        i_cps_host.access(1'b0, 1'b1, 8'h40, q);
        t = nTick;
        step(256);
        chk(nTick - t, 8);
        extClkSel = 1'b1;
        step(8);
        t = nTick;
        step(256);
        chk(nTick - t, 0);
        i_cps_host.access(1'b0, 1'b1, 8'h00, q);
        chk(oscRun_r, 1'b1);
    endtask
    initial
    begin
        step(6);
        nrst = 1'b1;
        step(2);
        t_cmd();
        t_load();
        t_user();
        t_osc();
        stop_test();
    end
endmodule
